// ---- guard_pkg.sv ----
// Constants and types shared by the special register write guard
`default_nettype none
package guard_pkg;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 8;

  // Byte addresses of the guarded and related registers
  localparam logic [31:0] ADDR_PROTECT_CMD   = 32'hfffff1fc;
  localparam logic [31:0] ADDR_POWER_SAVE    = 32'hfffff1fe;
  localparam logic [31:0] ADDR_WDOG_MODE     = 32'hfffff6c2;
  localparam logic [31:0] ADDR_SYS_STATUS    = 32'hfffff802;
  localparam logic [31:0] ADDR_CPU_CLOCK     = 32'hfffff828;
  localparam logic [31:0] ADDR_WDOG_RESET    = 32'hfffff82a;
  localparam logic [31:0] ADDR_IRQ_STATUS    = 32'hfffff8f0;
  localparam logic [31:0] ADDR_IRQ_MASK      = 32'hfffff8f2;
  // Anything at or above this address is a peripheral register
  localparam logic [31:0] PERIPH_BASE        = 32'hfffff000;

  localparam logic [7:0] RST_POWER_SAVE  = 8'h00;
  localparam logic [7:0] RST_CPU_CLOCK   = 8'h03;
  localparam logic [7:0] RST_WDOG_MODE   = 8'h00;
  localparam logic [7:0] RST_WDOG_RESET  = 8'h00;
  localparam logic [7:0] RST_ZERO        = 8'h00;
  // Value returned when the write-only command register is read
  localparam logic [7:0] CMD_READ_VALUE  = 8'h00;

  localparam int unsigned PROTECTION_ERROR_FLAG_BIT = 0;

  // Interrupt status / mask bit positions
  localparam int unsigned IRQ_ERR_BIT      = 0;
  localparam int unsigned IRQ_ACCEPT_BIT   = 1;
  localparam int unsigned IRQ_EVENTS       = 2;

  // Store operations issued by the core
  typedef enum logic [1:0] {
    OP_STORE,
    OP_SET,
    OP_CLEAR,
    OP_INVERT
  } store_op_t;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_POWER,
    SEL_CLOCK,
    SEL_WMODE,
    SEL_WRESET
  } guarded_sel_t;
endpackage : guard_pkg
`default_nettype wire

// ---- guarded_decode.sv ----
// Address classifier for guarded and peripheral stores
`default_nettype none
module guarded_decode
  import guard_pkg::*;
(
  input  wire logic [ADDR_W-1:0] addr,
  output var  guarded_sel_t      sel,
  output var  logic              is_cmd,
  output var  logic              is_periph
);
  always_comb begin
    is_cmd    = (addr == ADDR_PROTECT_CMD);
    is_periph = (addr >= PERIPH_BASE);
    case (addr)
      ADDR_POWER_SAVE: sel = SEL_POWER;
      ADDR_CPU_CLOCK:  sel = SEL_CLOCK;
      ADDR_WDOG_MODE:  sel = SEL_WMODE;
      ADDR_WDOG_RESET: sel = SEL_WRESET;
      default:         sel = SEL_NONE;
    endcase
  end
endmodule : guarded_decode
`default_nettype wire

// ---- bit_modify.sv ----
// Applies a store or bit set/clear/invert to an 8-bit value
`default_nettype none
module bit_modify
  import guard_pkg::*;
(
  input  wire logic [DATA_W-1:0] old_value,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire store_op_t         op,
  output var  logic [DATA_W-1:0] new_value
);
  // For bit ops wdata is a bit mask; every set bit is affected
  always_comb begin
    case (op)
      OP_STORE:  new_value = wdata;
      OP_SET:    new_value = old_value | wdata;
      OP_CLEAR:  new_value = old_value & ~wdata;
      OP_INVERT: new_value = old_value ^ wdata;
      default:   new_value = wdata;
    endcase
  end
endmodule : bit_modify
`default_nettype wire

// ---- special_register_write_guard.sv ----
// Write guard for the special registers behind an unlock command register
`default_nettype none
module special_register_write_guard
  import guard_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst_b,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire store_op_t         op,
  input  wire logic              rd,
  output var  logic [DATA_W-1:0] rdata,
  output var  logic              irq_ack_block,
  output var  logic              irq,
  output var  logic [DATA_W-1:0] power_save_control,
  output var  logic [DATA_W-1:0] cpu_clock_ctl,
  output var  logic [DATA_W-1:0] watchdog_mode_ctl,
  output var  logic [DATA_W-1:0] watchdog_reset_state
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [DATA_W-1:0] power;
    logic [DATA_W-1:0] clk;
    logic [DATA_W-1:0] wmode;
    logic [DATA_W-1:0] wreset;
    logic [DATA_W-1:0] system_status_flags;
    logic              unlocked;
    logic              read_seen;
    logic              ack_block;
    logic [IRQ_EVENTS-1:0] irq_status;
    logic [IRQ_EVENTS-1:0] irq_mask;
    logic              irq;
    logic [DATA_W-1:0] rdata;
  } state_t;

  state_t cur;
  state_t next_state;

  guarded_sel_t      sel;
  logic              is_cmd;
  logic              is_periph;
  logic [DATA_W-1:0] old_value;
  logic [DATA_W-1:0] new_value;

  guarded_decode u_decode (
    .addr      (addr),
    .sel       (sel),
    .is_cmd    (is_cmd),
    .is_periph (is_periph)
  );

  bit_modify u_modify (
    .old_value (old_value),
    .wdata     (wdata),
    .op        (op),
    .new_value (new_value)
  );

  function automatic logic [DATA_W-1:0] read_mux(input logic [ADDR_W-1:0] a, input state_t s);
    case (a)
      ADDR_POWER_SAVE:  read_mux = s.power;
      ADDR_CPU_CLOCK:   read_mux = s.clk;
      ADDR_WDOG_MODE:   read_mux = s.wmode;
      ADDR_WDOG_RESET:  read_mux = s.wreset;
      ADDR_SYS_STATUS:  read_mux = s.system_status_flags;
      ADDR_PROTECT_CMD: read_mux = CMD_READ_VALUE;
      ADDR_IRQ_STATUS:  read_mux = {{(DATA_W-IRQ_EVENTS){1'b0}}, s.irq_status};
      ADDR_IRQ_MASK:    read_mux = {{(DATA_W-IRQ_EVENTS){1'b0}}, s.irq_mask};
      default:          read_mux = RST_ZERO;
    endcase
  endfunction : read_mux

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic accept;
    logic err_set;
    logic err_clr;
    logic [IRQ_EVENTS-1:0] ev;
    accept     = 1'b0;
    err_set    = 1'b0;
    err_clr    = 1'b0;
    ev         = '0;
    next_state = cur;

    case (sel)
      SEL_POWER:  old_value = cur.power;
      SEL_CLOCK:  old_value = cur.clk;
      SEL_WMODE:  old_value = cur.wmode;
      SEL_WRESET: old_value = cur.wreset;
      default:    old_value = (addr == ADDR_SYS_STATUS) ? cur.system_status_flags : RST_ZERO;
    endcase

    // Command store is one cycle; block acknowledgement for the next
    next_state.ack_block = wr && is_cmd;

    if (wr) begin
      if (sel != SEL_NONE) begin
        if (cur.unlocked && !(sel == SEL_WMODE && cur.read_seen)) begin
          accept = 1'b1;
        end else begin
          err_set = 1'b1;
        end
      end else if (cur.unlocked && is_periph) begin
        err_set = 1'b1;
      end
      // Any peripheral store ends the unlock window; a command re-arms only when locked
      if (is_periph) begin
        next_state.unlocked  = is_cmd && !cur.unlocked;
        next_state.read_seen = 1'b0;
      end
    end else if (rd && cur.unlocked) begin
      // A read in the gap keeps the unlock but spoils a watchdog mode store
      next_state.read_seen = 1'b1;
    end

    if (accept) begin
      case (sel)
        SEL_POWER:  next_state.power  = new_value;
        SEL_CLOCK:  next_state.clk    = new_value;
        SEL_WMODE:  next_state.wmode  = new_value;
        SEL_WRESET: next_state.wreset = new_value;
        default:    next_state.power  = cur.power;
      endcase
    end

    if (wr && addr == ADDR_SYS_STATUS) begin
      next_state.system_status_flags = new_value;
      err_clr = !new_value[PROTECTION_ERROR_FLAG_BIT];
    end
    // A zero written to the flag right after a command wins over the set
    if (err_clr) begin
      next_state.system_status_flags[PROTECTION_ERROR_FLAG_BIT] = 1'b0;
    end else if (err_set) begin
      next_state.system_status_flags[PROTECTION_ERROR_FLAG_BIT] = 1'b1;
    end

    if (wr && addr == ADDR_IRQ_MASK) begin
      next_state.irq_mask = wdata[IRQ_EVENTS-1:0];
    end
    ev[IRQ_ERR_BIT]    = err_set;
    ev[IRQ_ACCEPT_BIT] = accept;
    // Read clears status, but a new event in that cycle survives
    if (rd && addr == ADDR_IRQ_STATUS) begin
      next_state.irq_status = ev;
    end else begin
      next_state.irq_status = cur.irq_status | ev;
    end
    next_state.irq = |(next_state.irq_status & next_state.irq_mask);

    // Reads return data without touching the unlock
    next_state.rdata = rd ? read_mux(addr, cur) : RST_ZERO;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cur            <= '0;
      cur.power      <= RST_POWER_SAVE;
      cur.clk        <= RST_CPU_CLOCK;
      cur.wmode      <= RST_WDOG_MODE;
      cur.wreset     <= RST_WDOG_RESET;
      cur.system_status_flags        <= RST_ZERO;
      cur.unlocked   <= 1'b0;
    end else begin
      cur <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign rdata                = cur.rdata;
  assign irq_ack_block        = cur.ack_block;
  assign irq                  = cur.irq;
  assign power_save_control   = cur.power;
  assign cpu_clock_ctl        = cur.clk;
  assign watchdog_mode_ctl    = cur.wmode;
  assign watchdog_reset_state = cur.wreset;

endmodule : special_register_write_guard
`default_nettype wire

// ---- guard_checker_assertions.sv ----
// Port-level checks of the special register write guard
`default_nettype none
module guard_checker
  import guard_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire store_op_t op,
  input wire logic rd,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic irq_ack_block,
  input wire logic [DATA_W-1:0] cpu_clock_ctl,
  input wire logic [DATA_W-1:0] watchdog_reset_state
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic armed;
  wire cmd_wr = wr && addr == ADDR_PROTECT_CMD;
  // Unlock mirror: a second command store consumes it instead of re-arming
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b) armed <= 1'b0;
    else if (wr && addr >= PERIPH_BASE) armed <= cmd_wr && !armed;
  ack_hold_a:
    assert property (cmd_wr |=> irq_ack_block) else $error("ack hold missing");
  locked_clock_a:
    assert property (wr && addr == ADDR_CPU_CLOCK && !armed |=> $stable(cpu_clock_ctl))
      else $error("locked clock write took effect");
  unlock_store_a:
    assert property (wr && addr == ADDR_CPU_CLOCK && op == OP_STORE && armed
      |=> cpu_clock_ctl == $past(wdata)) else $error("unlocked store lost");
  bit_set_a:
    assert property (wr && addr == ADDR_WDOG_RESET && op == OP_SET && armed
      |=> watchdog_reset_state == ($past(watchdog_reset_state) | $past(wdata)))
      else $error("bit set wrong");
  read_back_a:
    assert property (rd && addr == ADDR_CPU_CLOCK |=> rdata == cpu_clock_ctl)
      else $error("clock read wrong");
  cmd_read_a:
    assert property (rd && addr == ADDR_PROTECT_CMD |=> rdata == CMD_READ_VALUE)
      else $error("command read wrong");
  err_set_a:
    assert property (wr && addr == ADDR_POWER_SAVE && !armed ##1 rd
      && addr == ADDR_SYS_STATUS |=> rdata[PROTECTION_ERROR_FLAG_BIT]) else $error("error flag not set");
  err_clear_a:
    assert property (wr && addr == ADDR_SYS_STATUS && !wdata[PROTECTION_ERROR_FLAG_BIT] ##1 rd
      && addr == ADDR_SYS_STATUS |=> !rdata[PROTECTION_ERROR_FLAG_BIT]) else $error("error flag not clear");
endmodule : guard_checker
bind special_register_write_guard guard_checker guard_checker_inst (.clock, .rst_b, .addr,
  .wdata, .wr, .op, .rd, .rdata, .irq_ack_block, .cpu_clock_ctl, .watchdog_reset_state);
`default_nettype wire

// ---- core_store_model.sv ----
// Behavioural core issuing peripheral stores and loads
`default_nettype none
module core_store_model
  import guard_pkg::*;
(
  input  wire logic              clock,
  output var  logic [ADDR_W-1:0] addr,
  output var  logic [DATA_W-1:0] wdata,
  output var  logic              wr,
  output var  store_op_t         op,
  output var  logic              rd,
  input  wire logic [DATA_W-1:0] rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {addr, wdata, wr, rd} = '0;
    op = OP_STORE;
  end
  task put(input logic [31:0] a, input logic [7:0] d, input store_op_t o);
    @(posedge clock);
    {addr, wdata, wr, rd} <= {a, d, 2'b10};
    op <= o;
  endtask : put
  task get(input logic [31:0] a, output logic [7:0] d);
    @(posedge clock);
    {addr, wr, rd} <= {a, 2'b01};
    @(posedge clock);
    rd <= 1'b0;
    // Released data lines show a changing pattern, not the last value
    wdata <= ~wdata;
    #1 d = rdata;
  endtask : get
  // Command and guarded store use the same data word, with no gap between them
  task protect(input logic [31:0] a, input logic [7:0] d, input store_op_t o);
    put(ADDR_PROTECT_CMD, d, OP_STORE);
    put(a, d, o);
    @(posedge clock);
    wr <= 1'b0;
    // Let the register update settle before the caller looks at it
    #1;
    if (a == ADDR_POWER_SAVE) repeat (4) @(posedge clock);
  endtask : protect
endmodule : core_store_model
`default_nettype wire

// ---- tb_special_register_write_guard.sv ----
// Self-checking bench for the special register write guard
`default_nettype none
module tb_special_register_write_guard import guard_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [31:0] addr;
  logic [7:0] wdata, rdata, pwr, clk_r, wmode, wres, got, exp;
  logic wr, rd, ack, irq;
  store_op_t op;
  store_op_t ops [4] = '{OP_SET, OP_CLEAR, OP_INVERT, OP_STORE};
  logic [7:0] msk [4] = '{8'h0f, 8'h03, 8'hff, 8'h5a};
  int error_cnt = 0;
  int checks = 0;
  initial forever #50 clock = ~clock;
  special_register_write_guard special_register_write_guard_inst (.clock, .rst_b, .addr,
    .wdata, .wr, .op, .rd, .rdata, .irq_ack_block(ack), .irq, .power_save_control(pwr),
    .cpu_clock_ctl(clk_r), .watchdog_mode_ctl(wmode), .watchdog_reset_state(wres));
  core_store_model core (.clock, .addr, .wdata, .wr, .op, .rd, .rdata);
  task chk(input string what, input logic [7:0] e, input logic [7:0] s);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, e, s);
    end
  endtask : chk
  task rdchk(input logic [31:0] a, input logic [7:0] e);
    core.get(a, got);
    chk($sformatf("read %h", a), e, got);
  endtask : rdchk
  task summarize();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  initial begin
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    rdchk(ADDR_CPU_CLOCK, RST_CPU_CLOCK);
    core.put(ADDR_POWER_SAVE, 8'h01, OP_STORE);
    rdchk(ADDR_SYS_STATUS, 8'h01);
    chk("power", RST_POWER_SAVE, pwr);
    chk("irq masked", 8'h00, {7'h0, irq});
    core.put(ADDR_SYS_STATUS, 8'h00, OP_STORE);
    rdchk(ADDR_SYS_STATUS, 8'h00);
    core.put(ADDR_IRQ_MASK, 8'h03, OP_STORE);
    core.protect(ADDR_CPU_CLOCK, 8'h01, OP_STORE);
    rdchk(ADDR_CPU_CLOCK, 8'h01);
    chk("irq", 8'h01, {7'h0, irq});
    rdchk(ADDR_IRQ_STATUS, 8'h03);
    rdchk(ADDR_SYS_STATUS, 8'h00);
    chk("irq cleared", 8'h00, {7'h0, irq});
    $display("test basic done");
    exp = RST_WDOG_RESET;
    foreach (ops[i]) begin
      core.protect(ADDR_WDOG_RESET, msk[i], ops[i]);
      case (ops[i])
        OP_SET:    exp = exp | msk[i];
        OP_CLEAR:  exp = exp & ~msk[i];
        OP_INVERT: exp = exp ^ msk[i];
        default:   exp = msk[i];
      endcase
      chk("wdog reset", exp, wres);
    end
    core.protect(ADDR_POWER_SAVE, 8'h02, OP_STORE);
    chk("power", 8'h02, pwr);
    $display("test ops done");
    core.put(ADDR_PROTECT_CMD, 8'h11, OP_STORE);
    rdchk(ADDR_PROTECT_CMD, CMD_READ_VALUE);
    core.put(ADDR_CPU_CLOCK, 8'h11, OP_STORE);
    rdchk(ADDR_SYS_STATUS, 8'h00);
    core.put(ADDR_PROTECT_CMD, 8'h11, OP_STORE);
    rdchk(ADDR_WDOG_MODE, RST_WDOG_MODE);
    core.put(ADDR_WDOG_MODE, 8'h11, OP_STORE);
    rdchk(ADDR_SYS_STATUS, 8'h01);
    chk("wdog mode", RST_WDOG_MODE, wmode);
    core.put(ADDR_PROTECT_CMD, 8'h07, OP_STORE);
    core.put(ADDR_PROTECT_CMD, 8'h07, OP_STORE);
    core.put(ADDR_CPU_CLOCK, 8'h07, OP_STORE);
    core.put(ADDR_PROTECT_CMD, 8'h00, OP_STORE);
    core.put(ADDR_SYS_STATUS, 8'h00, OP_STORE);
    rdchk(ADDR_SYS_STATUS, 8'h00);
    chk("clock", 8'h11, clk_r);
    core.put(ADDR_PROTECT_CMD, 8'h22, OP_STORE);
    core.put(32'h00001000, 8'h22, OP_STORE);
    core.put(ADDR_WDOG_MODE, 8'h22, OP_STORE);
    rdchk(ADDR_WDOG_MODE, 8'h22);
    $display("test sequence done");
    summarize();
  end
endmodule : tb_special_register_write_guard
`default_nettype wire
